// ### hw/scpr_pkg.sv
package scpr_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [6:0] ADDR_USER_CONTROL   = 7'h6a;  // User control register.
  localparam logic [6:0] ADDR_POWER_MAIN     = 7'h6b;  // Main power control register.
  localparam logic [6:0] ADDR_POWER_AXES     = 7'h6c;  // Per-axis power control register.

  localparam logic [7:0] RST_USER_CONTROL    = 8'h00;  // Default of user control.
  localparam logic [7:0] RST_POWER_MAIN      = 8'h40;  // Default of main power: asleep.
  localparam logic [7:0] RST_POWER_AXES      = 8'h00;  // Default of axis power: all on.
  localparam logic [7:0] MASK_USER_CONTROL   = 8'hdd;  // Bits 5 and 1 are reserved.

  // ---------------------------------------------------------------------------
  // User control fields
  // ---------------------------------------------------------------------------
  localparam int UC_MOTION_PROC_ENABLE = 7;  // Motion coprocessor enable.
  localparam int UC_QUEUE_ENABLE       = 6;  // Sample queue operation enable.
  localparam int UC_TWOWIRE_DISABLE    = 4;  // Two-wire slave port off.
  localparam int UC_MOTION_PROC_RESET  = 3;  // Motion coprocessor reset.
  localparam int UC_QUEUE_RESET        = 2;  // Sample queue reset.
  localparam int UC_SENSOR_PATH_RESET  = 0;  // Sensor path reset.

  // ---------------------------------------------------------------------------
  // Main power fields
  // ---------------------------------------------------------------------------
  localparam int PM_DEVICE_RESET = 7;  // Full device reset.
  localparam int PM_SLEEP        = 6;  // Sleep mode.
  localparam int PM_ACCEL_CYCLE  = 5;  // Accelerometer duty cycling.
  localparam int PM_GYRO_STANDBY = 4;  // Gyro standby.
  localparam int PM_THERMO_OFF   = 3;  // Temperature sensor off.
  localparam int PM_CLK_HI       = 2;  // Clock source field, top bit.
  localparam int PM_CLK_LO       = 0;  // Clock source field, bottom bit.

  // ---------------------------------------------------------------------------
  // Axis power fields
  // ---------------------------------------------------------------------------
  localparam int PA_QUEUE_LP_KEEP   = 7;  // Queue kept in low-power mode.
  localparam int PA_MOTION_LP_OFF   = 6;  // Coprocessor stopped in low-power mode.
  localparam int PA_X_ACCEL_OFF     = 5;  // X accelerometer off.
  localparam int PA_Y_ACCEL_OFF     = 4;  // Y accelerometer off.
  localparam int PA_Z_ACCEL_OFF     = 3;  // Z accelerometer off.
  localparam int PA_X_RATE_OFF      = 2;  // X gyro off.
  localparam int PA_Y_RATE_OFF      = 1;  // Y gyro off.
  localparam int PA_Z_RATE_OFF      = 0;  // Z gyro off.

  // ---------------------------------------------------------------------------
  // Clock source codes
  // ---------------------------------------------------------------------------
  localparam logic [2:0] CLK_CODE_AUTO_LO = 3'h1;  // First automatic code.
  localparam logic [2:0] CLK_CODE_AUTO_HI = 3'h5;  // Last automatic code.
  localparam logic [2:0] CLK_CODE_STOP    = 3'h7;  // Clock stopped.

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLOCK_MHZ      = 20;    // System clock rate in MHz.
  localparam int BASE_PERIOD_US = 1000;  // Base sample period in microseconds.
  localparam int BASE_PERIOD_CYCLES = BASE_PERIOD_US * CLOCK_MHZ;  // Cycles per base tick.

  // Clock code decode: true for codes that prefer the PLL.
  function automatic logic scpr_wants_pll(input logic [2:0] code);
    scpr_wants_pll = (code >= CLK_CODE_AUTO_LO) && (code <= CLK_CODE_AUTO_HI);
  endfunction

endpackage

// ### hw/scpr_cycle_if.sv
`timescale 1ns/1ns
// Link between the register bank and the duty-cycle pacer.
interface scpr_cycle_if;
  logic       enable;          // Pacer runs while high.
  logic [7:0] sample_divider;  // Rate divider, wake every divider+1 base ticks.
  logic       wake;            // One-cycle wake pulse.

  modport ctrl  (output enable, output sample_divider, input wake);
  modport pacer (input enable, input sample_divider, output wake);
endinterface

// ### hw/scpr_pacer.sv
`timescale 1ns/1ns
module scpr_pacer
  import scpr_pkg::*;
#(
  parameter int TICK_CYCLES = BASE_PERIOD_CYCLES  // Cycles per base tick.
) (
  input  wire logic    clock,  // System clock.
  input  wire logic    resetn, // Asynchronous reset, active low.
  scpr_cycle_if.pacer  cyc     // Control link.
);

  // ---------------------------------------------------------------------------
  // Base tick prescaler
  // ---------------------------------------------------------------------------
  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

  logic [PW-1:0] pre_q;  // Prescaler count.
  logic [7:0]    div_q;  // Base ticks since the last wake.
  logic          tick;   // Base tick enable.

  assign tick = cyc.enable && (pre_q == PRE_LAST);

  // Prescaler restarts whenever cycling is turned off so wakes are phase-aligned.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pre_q <= '0;
    end else if (!cyc.enable || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // Divider counts base ticks; wake after divider+1 ticks.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_q    <= '0;
      cyc.wake <= 1'b0;
    end else begin
      cyc.wake <= 1'b0;
      if (!cyc.enable) begin
        div_q <= '0;
      end else if (tick) begin
        if (div_q >= cyc.sample_divider) begin
          div_q    <= '0;
          cyc.wake <= 1'b1;
        end else begin
          div_q <= div_q + 1'b1;
        end
      end
    end
  end

endmodule

// ### hw/scpr_regs.sv
`timescale 1ns/1ns
module scpr_regs
  import scpr_pkg::*;
#(
  parameter int TICK_CYCLES = BASE_PERIOD_CYCLES  // Cycles per base tick.
) (
  input  wire logic       clock,               // System clock, 20 MHz.
  input  wire logic       resetn,              // Asynchronous reset, active low.
  input  wire logic       wr_en,               // Register write strobe.
  input  wire logic       rd_en,               // Register read strobe.
  input  wire logic [6:0] addr,                // Register address.
  input  wire logic [7:0] wr_data,             // Write data.
  input  wire logic [7:0] sample_divider,      // Sample rate divider value.
  input  wire logic       pll_ready,           // PLL is locked and usable.
  output logic      [7:0] rd_data_q,           // Read data, one cycle after rd_en.
  output logic            queue_run_q,         // Sample queue operating.
  output logic            queue_port_open_q,   // Serial access to queue allowed.
  output logic            queue_reset_q,       // Queue reset pulse.
  output logic            twowire_off_q,       // Two-wire slave off, SPI only.
  output logic            motion_proc_run_q,   // Motion coprocessor running.
  output logic            motion_proc_reset_q, // Motion coprocessor reset pulse.
  output logic            sensor_path_reset_q, // Sensor signal path reset pulse.
  output logic            sensor_data_clear_q, // Sensor data register clear pulse.
  output logic            device_reset_q,      // Full device reset pulse.
  output logic            sleep_q,             // Device asleep.
  output logic            wake_q,              // Duty-cycle wake pulse.
  output logic            accel_sample_q,      // Take one accel sample pulse.
  output logic      [2:0] accel_axis_on_q,     // Accel axes on, [0]=X [1]=Y [2]=Z.
  output logic            gyro_drive_on_q,     // Gyro drive and PLL powered.
  output logic      [2:0] gyro_sense_on_q,     // Gyro sense paths on, [0]=X.
  output logic            thermo_on_q,         // Temperature sensor on.
  output logic            clk_use_pll_q,       // Timing runs from the PLL.
  output logic            clk_stopped_q,       // Timing clock stopped.
  output logic            timing_gen_reset_q   // Timing generator held in reset.
);

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  logic [7:0] user_control_q;        // User control.
  logic [7:0] power_control_main_q;  // Main power control.
  logic [7:0] power_control_axes_q;  // Per-axis power control.
  logic       wr_uc;                 // Write to user control.
  logic       wr_pm;                 // Write to main power control.
  logic       wr_pa;                 // Write to axis power control.
  logic       dev_rst;               // Device reset requested last cycle.
  logic       lowpower;              // Low-power accelerometer cycling active.
  logic [2:0] clk_code;              // Clock source field.

  assign wr_uc    = wr_en && (addr == ADDR_USER_CONTROL);
  assign wr_pm    = wr_en && (addr == ADDR_POWER_MAIN);
  assign wr_pa    = wr_en && (addr == ADDR_POWER_AXES);
  assign dev_rst  = power_control_main_q[PM_DEVICE_RESET];
  assign clk_code = power_control_main_q[PM_CLK_HI:PM_CLK_LO];

  // Cycling counts only when neither sleep nor gyro standby is set.
  assign lowpower = power_control_main_q[PM_ACCEL_CYCLE] &&
                    !power_control_main_q[PM_SLEEP] &&
                    !power_control_main_q[PM_GYRO_STANDBY];

  // User control. Reset bits self-clear after one cycle unless rewritten,
  // so a host write in the clearing cycle wins over the clear.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      user_control_q <= RST_USER_CONTROL;
    end else if (dev_rst) begin
      user_control_q <= RST_USER_CONTROL;
    end else if (wr_uc) begin
      user_control_q <= wr_data & MASK_USER_CONTROL;
    end else begin
      user_control_q[UC_QUEUE_RESET]       <= 1'b0;
      user_control_q[UC_MOTION_PROC_RESET] <= 1'b0;
      user_control_q[UC_SENSOR_PATH_RESET] <= 1'b0;
    end
  end

  // Main power control. Device reset takes one cycle and then reads zero.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      power_control_main_q <= RST_POWER_MAIN;
    end else if (dev_rst) begin
      power_control_main_q <= RST_POWER_MAIN;
    end else if (wr_pm) begin
      power_control_main_q <= wr_data;
    end
  end

  // Axis power control.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      power_control_axes_q <= RST_POWER_AXES;
    end else if (dev_rst) begin
      power_control_axes_q <= RST_POWER_AXES;
    end else if (wr_pa) begin
      power_control_axes_q <= wr_data;
    end
  end

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  // Unmapped addresses read zero; the serial front end owns the other registers.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_data_q <= '0;
    end else if (rd_en) begin
      case (addr)
        ADDR_USER_CONTROL: rd_data_q <= user_control_q;
        ADDR_POWER_MAIN:   rd_data_q <= power_control_main_q;
        ADDR_POWER_AXES:   rd_data_q <= power_control_axes_q;
        default:           rd_data_q <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Queue, coprocessor and port controls
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      queue_run_q         <= 1'b0;
      queue_port_open_q   <= 1'b0;
      queue_reset_q       <= 1'b0;
      twowire_off_q       <= 1'b0;
      motion_proc_run_q   <= 1'b0;
      motion_proc_reset_q <= 1'b0;
    end else begin
      // In low-power mode the queue needs its keep bit as well.
      queue_run_q <= user_control_q[UC_QUEUE_ENABLE] &&
                     (!lowpower || power_control_axes_q[PA_QUEUE_LP_KEEP]);
      queue_port_open_q   <= user_control_q[UC_QUEUE_ENABLE];
      queue_reset_q       <= user_control_q[UC_QUEUE_RESET];
      twowire_off_q       <= user_control_q[UC_TWOWIRE_DISABLE];
      motion_proc_run_q   <= user_control_q[UC_MOTION_PROC_ENABLE] &&
                             !(lowpower && power_control_axes_q[PA_MOTION_LP_OFF]);
      motion_proc_reset_q <= user_control_q[UC_MOTION_PROC_RESET];
    end
  end

  // Reset pulses toward the sensor paths and the rest of the device.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sensor_path_reset_q <= 1'b0;
      sensor_data_clear_q <= 1'b0;
      device_reset_q      <= 1'b0;
    end else begin
      sensor_path_reset_q <= user_control_q[UC_SENSOR_PATH_RESET];
      sensor_data_clear_q <= user_control_q[UC_SENSOR_PATH_RESET];
      device_reset_q      <= dev_rst;
    end
  end

  // ---------------------------------------------------------------------------
  // Power state of the sensors
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sleep_q         <= 1'b1;
      accel_axis_on_q <= '0;
      gyro_drive_on_q <= 1'b0;
      gyro_sense_on_q <= '0;
      thermo_on_q     <= 1'b0;
    end else begin
      sleep_q         <= power_control_main_q[PM_SLEEP];
      accel_axis_on_q <= ~{power_control_axes_q[PA_Z_ACCEL_OFF],
                           power_control_axes_q[PA_Y_ACCEL_OFF],
                           power_control_axes_q[PA_X_ACCEL_OFF]};
      // Standby leaves the drive up so the gyros come back fast.
      gyro_drive_on_q <= !power_control_main_q[PM_SLEEP];
      gyro_sense_on_q <= ~{power_control_axes_q[PA_Z_RATE_OFF],
                           power_control_axes_q[PA_Y_RATE_OFF],
                           power_control_axes_q[PA_X_RATE_OFF]} &
                         {3{!power_control_main_q[PM_SLEEP] &&
                            !power_control_main_q[PM_GYRO_STANDBY]}};
      thermo_on_q     <= !power_control_main_q[PM_THERMO_OFF] &&
                         !power_control_main_q[PM_SLEEP];
    end
  end

  // ---------------------------------------------------------------------------
  // Clock source selection
  // ---------------------------------------------------------------------------
  // Any code not preferring the PLL and not stop runs on the oscillator.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      clk_use_pll_q      <= 1'b0;
      clk_stopped_q      <= 1'b0;
      timing_gen_reset_q <= 1'b0;
    end else begin
      clk_use_pll_q      <= scpr_wants_pll(clk_code) && pll_ready;
      clk_stopped_q      <= (clk_code == CLK_CODE_STOP);
      timing_gen_reset_q <= (clk_code == CLK_CODE_STOP);
    end
  end

  // ---------------------------------------------------------------------------
  // Accelerometer duty cycling
  // ---------------------------------------------------------------------------
  scpr_cycle_if cyc ();

  assign cyc.enable         = lowpower;
  assign cyc.sample_divider = sample_divider;

  scpr_pacer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_pacer (
    .clock  (clock),
    .resetn (resetn),
    .cyc    (cyc)
  );

  // A wake with every axis off takes no sample.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wake_q         <= 1'b0;
      accel_sample_q <= 1'b0;
    end else begin
      wake_q         <= cyc.wake && lowpower;
      accel_sample_q <= cyc.wake && lowpower &&
                        (power_control_axes_q[PA_Z_ACCEL_OFF:PA_X_ACCEL_OFF] != 3'h7);
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence uc_queue_reset_write;
    wr_uc && wr_data[UC_QUEUE_RESET] && !dev_rst;
  endsequence

  sequence queue_reset_one_pulse;
    ##1 queue_reset_q ##1 !queue_reset_q;
  endsequence

  queue_reset_pulse_a: assert property (
    uc_queue_reset_write ##1 !wr_uc |-> queue_reset_one_pulse)
    else $error("queue reset not a single pulse");

  device_reset_defaults_a: assert property (
    dev_rst |=> power_control_main_q == RST_POWER_MAIN &&
                user_control_q == RST_USER_CONTROL && !dev_rst)
    else $error("device reset did not restore defaults");

  queue_run_follow_a: assert property (
    !user_control_q[UC_QUEUE_ENABLE] |=> !queue_run_q && !queue_port_open_q)
    else $error("queue runs while disabled");

  twowire_off_a: assert property (
    wr_uc && !dev_rst |-> ##2 twowire_off_q == $past(wr_data[UC_TWOWIRE_DISABLE], 2))
    else $error("two-wire disable not applied");

  sensor_clear_pair_a: assert property (
    sensor_path_reset_q |-> sensor_data_clear_q ##1 !sensor_path_reset_q)
    else $error("sensor clear not paired with path reset");

  clk_pll_pick_a: assert property (
    scpr_wants_pll(clk_code) && pll_ready |=> clk_use_pll_q)
    else $error("pll not selected when ready");

  clk_osc_pick_a: assert property (
    !scpr_wants_pll(clk_code) |=> !clk_use_pll_q)
    else $error("pll used for oscillator code");

  clk_stop_hold_a: assert property (
    clk_code == CLK_CODE_STOP |=> clk_stopped_q && timing_gen_reset_q)
    else $error("stop code did not stop timing");

  gyro_standby_mode_a: assert property (
    power_control_main_q[PM_GYRO_STANDBY] && !power_control_main_q[PM_SLEEP]
      |=> gyro_drive_on_q && gyro_sense_on_q == 3'h0)
    else $error("gyro standby wrong");

  no_sample_off_a: assert property (
    power_control_axes_q[PA_Z_ACCEL_OFF:PA_X_ACCEL_OFF] == 3'h7 |=> !accel_sample_q)
    else $error("sample taken with all axes off");

  wake_only_cycling_a: assert property (
    !lowpower |=> !wake_q)
    else $error("wake outside cycling");

endmodule

// ### test/scpr_host_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Host model: issues register cycles to the bank, one strobe per access.
// ---------------------------------------------------------------------------
module scpr_host_model (
  input  wire logic       clock,   // System clock.
  input  wire logic [7:0] rd_data, // Read data from the bank.
  output logic            wr_en,   // Write strobe.
  output logic            rd_en,   // Read strobe.
  output logic      [6:0] addr,    // Register address.
  output logic      [7:0] wr_data  // Write data.
);
  // All strobes idle from time zero, so reset sees no stray access.
  initial {wr_en, rd_en, addr, wr_data} = '0;
  // A write holds its strobe for exactly one sampling edge.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  // A read takes the data once the answering edge has settled.
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clock);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask
endmodule

// ### test/testbench.sv
`timescale 1ns/1ns
module testbench
  import scpr_pkg::*;
;
  logic       clock, resetn, pll_ready, wr_en, rd_en;   // Drive side.
  logic [6:0] addr;                                     // Register address.
  logic [7:0] wr_data, sample_divider, rd_data_q, v;    // Data paths.
  logic       queue_run_q, queue_port_open_q, queue_reset_q, twowire_off_q;
  logic       motion_proc_run_q, motion_proc_reset_q, sensor_path_reset_q;
  logic       sensor_data_clear_q, device_reset_q, sleep_q, wake_q;
  logic       accel_sample_q, gyro_drive_on_q, thermo_on_q, clk_use_pll_q;
  logic       clk_stopped_q, timing_gen_reset_q;
  logic [2:0] accel_axis_on_q, gyro_sense_on_q;         // Axis status.
  logic [7:0] wakes, samples;                           // Pacer pulse counts.
  int         err_total, checks_done;                   // Verdict counters.
  // Short tick keeps the duty-cycle run brief: one wake every 4*(div+1).
  scpr_regs #(.TICK_CYCLES(4)) scpr_regs_i (
    .clock(clock), .resetn(resetn), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .sample_divider(sample_divider), .pll_ready(pll_ready),
    .rd_data_q(rd_data_q), .queue_run_q(queue_run_q),
    .queue_port_open_q(queue_port_open_q),
    .queue_reset_q(queue_reset_q), .twowire_off_q(twowire_off_q),
    .motion_proc_run_q(motion_proc_run_q), .motion_proc_reset_q(motion_proc_reset_q),
    .sensor_path_reset_q(sensor_path_reset_q), .sensor_data_clear_q(sensor_data_clear_q),
    .device_reset_q(device_reset_q), .sleep_q(sleep_q), .wake_q(wake_q),
    .accel_sample_q(accel_sample_q), .accel_axis_on_q(accel_axis_on_q),
    .gyro_drive_on_q(gyro_drive_on_q), .gyro_sense_on_q(gyro_sense_on_q),
    .thermo_on_q(thermo_on_q), .clk_use_pll_q(clk_use_pll_q),
    .clk_stopped_q(clk_stopped_q), .timing_gen_reset_q(timing_gen_reset_q));
  scpr_host_model scpr_host_model_i (.clock(clock), .rd_data(rd_data_q),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Derived outputs follow the register one edge later.
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask
  // Reset bits give a single pulse on the second edge after the write.
  task automatic pulse(input logic [7:0] d, input logic [3:0] e);
    scpr_host_model_i.wr(ADDR_USER_CONTROL, d);
    @(posedge clock);
    #1;
    chk({queue_reset_q, motion_proc_reset_q, sensor_path_reset_q, sensor_data_clear_q}, e);
    @(posedge clock);
    #1;
    chk({queue_reset_q, motion_proc_reset_q, sensor_path_reset_q, sensor_data_clear_q}, 4'h0);
  endtask
  // Counts pacer pulses over 80 cycles, a whole number of periods.
  task automatic count();
    wakes = 0;
    samples = 0;
    repeat (10) @(posedge clock);
    repeat (80) begin
      @(posedge clock);
      #1;
      wakes = wakes + 8'(wake_q);
      samples = samples + 8'(accel_sample_q);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // The tests need well under 2000 cycles; this span is far beyond.
  initial begin
    #2000000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    {resetn, pll_ready, sample_divider, err_total, checks_done} = '0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    scpr_host_model_i.rd(ADDR_USER_CONTROL, v);
    chk(v, 8'h00);
    scpr_host_model_i.rd(ADDR_POWER_MAIN, v);
    chk(v, 8'h40);
    scpr_host_model_i.rd(ADDR_POWER_AXES, v);
    chk(v, 8'h00);
    scpr_host_model_i.rd(7'h10, v);
    chk(v, 8'h00);
    chk(sleep_q, 1'b1);
    $display("test reset values done");
    scpr_host_model_i.wr(ADDR_USER_CONTROL, 8'hff);
    settle();
    chk({queue_port_open_q, twowire_off_q, motion_proc_run_q}, 3'b111);
    scpr_host_model_i.rd(ADDR_USER_CONTROL, v);
    chk(v, 8'hd0);
    pulse(8'h04, 4'b1000);
    pulse(8'h08, 4'b0100);
    pulse(8'h01, 4'b0011);
    scpr_host_model_i.wr(ADDR_USER_CONTROL, 8'h00);
    settle();
    chk({queue_port_open_q, motion_proc_run_q, twowire_off_q}, 3'b000);
    $display("test user control done");
    @(posedge clock) pll_ready <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      scpr_host_model_i.wr(ADDR_POWER_MAIN, {5'h00, 3'(c)});
      settle();
      chk({clk_use_pll_q, clk_stopped_q, timing_gen_reset_q},
          (c >= 1 && c <= 5) ? 3'b100 : (c == 7) ? 3'b011 : 3'b000);
    end
    @(posedge clock) pll_ready <= 1'b0;
    scpr_host_model_i.wr(ADDR_POWER_MAIN, 8'h01);
    settle();
    chk({clk_use_pll_q, thermo_on_q, gyro_drive_on_q}, 3'b011);
    scpr_host_model_i.wr(ADDR_POWER_AXES, 8'h2a);
    settle();
    chk({accel_axis_on_q, gyro_sense_on_q}, 6'b010_101);
    scpr_host_model_i.wr(ADDR_POWER_MAIN, 8'h18);
    settle();
    chk({gyro_drive_on_q, gyro_sense_on_q, thermo_on_q}, 5'b10000);
    scpr_host_model_i.wr(ADDR_POWER_AXES, 8'hc0);
    scpr_host_model_i.rd(ADDR_POWER_AXES, v);
    chk(v, 8'hc0);
    $display("test power and clock done");
    @(posedge clock) sample_divider <= 8'h01;
    // Queue and coprocessor enabled; outside low-power mode both simply run.
    scpr_host_model_i.wr(ADDR_USER_CONTROL, 8'hc0);
    settle();
    chk({queue_run_q, motion_proc_run_q}, 2'h3);
    scpr_host_model_i.wr(ADDR_POWER_AXES, 8'h00);
    scpr_host_model_i.wr(ADDR_POWER_MAIN, 8'h20);
    count();
    chk(wakes, 8'h0a);
    chk(samples, 8'h0a);
    chk({queue_run_q, motion_proc_run_q}, 2'h1);
    scpr_host_model_i.wr(ADDR_POWER_AXES, 8'hf8);
    count();
    chk(wakes, 8'h0a);
    chk(samples, 8'h00);
    chk({queue_run_q, motion_proc_run_q}, 2'h2);
    scpr_host_model_i.wr(ADDR_POWER_MAIN, 8'h60);
    count();
    chk(wakes, 8'h00);
    chk({queue_run_q, motion_proc_run_q}, 2'h3);
    $display("test duty cycling done");
    scpr_host_model_i.wr(ADDR_USER_CONTROL, 8'h40);
    scpr_host_model_i.wr(ADDR_POWER_MAIN, 8'h80);
    @(posedge clock);
    #1;
    chk(device_reset_q, 1'b1);
    scpr_host_model_i.rd(ADDR_POWER_MAIN, v);
    chk(v, 8'h40);
    scpr_host_model_i.rd(ADDR_USER_CONTROL, v);
    chk(v, 8'h00);
    scpr_host_model_i.rd(ADDR_POWER_AXES, v);
    chk(v, 8'h00);
    $display("test device reset done");
    tally_and_finish();
  end
endmodule
